// >>> design/plc_defs.svh
// Purpose: constants of the power and lock configuration registers
// Assumes: included by plc_regs only
// Notes:   register byte address is four times the register index
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// register indices as used by the configuration index register
`define PLC_IDX_FPV       6'h00
`define PLC_IDX_PPL       6'h01
`define PLC_IDX_SPW       6'h02
`define PLC_IDX_LAST      6'h2f

// apb byte addresses
`define PLC_ADDR_FPV      12'h000
`define PLC_ADDR_PPL      12'h004
`define PLC_ADDR_SPW      12'h008
`define PLC_ADDR_CFGMODE  12'h100
`define PLC_ADDR_CFGINDEX 12'h104

// power-up values
`define PLC_RST_FPV       8'h28
`define PLC_RST_PPL       8'h9c
`define PLC_RST_SPW       8'h88

// writable bits and bits that always read as one
`define PLC_WMASK_FPV     8'h88
`define PLC_WMASK_PPL     8'h0c
`define PLC_WMASK_SPW     8'h88
`define PLC_ONES_FPV      8'h20
`define PLC_ONES_PPL      8'h10
`define PLC_ONES_SPW      8'h00
// fixed bits of the parallel register, lock bit excluded
`define PLC_FIXED_PPL     8'h73

// field positions
`define PLC_BIT_FLOP_PWR  3
`define PLC_BIT_VALID     7
`define PLC_BIT_PP_PWR    2
`define PLC_BIT_PP_MODE   3
`define PLC_BIT_LOCK      7
`define PLC_BIT_SP1_PWR   3
`define PLC_BIT_SP2_PWR   7
`define PLC_BIT_CFGMODE   0

// function slots
`define PLC_FN_FLOP       0
`define PLC_FN_PP         1
`define PLC_FN_SP1        2
`define PLC_FN_SP2        3

// host decoding stays off below this base address
`define PLC_DECODE_MIN    11'h100

// extended parallel setup codes
`define PLC_EXT_STD       2'h0
`define PLC_EXT_EPP       2'h1
`define PLC_EXT_ECP       2'h2
`define PLC_EXT_ECP_EPP   2'h3

`endif

// >>> design/plc_pkg.sv
// Purpose: types of the power and lock configuration registers
// Assumes: plc_defs.svh is not included; enum values are written out here
// Notes:   all state of plc_regs but the touched_r helper is one packed struct
package plc_pkg;

    // resulting parallel port operating mode
    typedef enum logic [2:0] {
        PLC_PP_PRINTER = 3'h0,
        PLC_PP_STD     = 3'h1,
        PLC_PP_EPP_STD = 3'h2,
        PLC_PP_ECP     = 3'h3,
        PLC_PP_ECP_EPP = 3'h4
    } plc_pp_mode_e;

    // base addresses of the four functions, floppy/pp/sp1/sp2
    typedef logic [3:0][10:0] plc_base_t;

    // controls towards the function units
    typedef struct packed {
        logic [3:0]   pwr_on;
        logic [3:0]   decode_en;
        logic         fir_pwr_on;
        plc_pp_mode_e pp_mode;
    } plc_fn_ctrl_s;

    // whole register state
    typedef struct packed {
        logic [7:0]   fpv;
        logic [7:0]   ppl;
        logic [7:0]   spw;
        logic         cfg_mode;
        logic [5:0]   cfg_index;
        logic [31:0]  prdata;
        logic         pslverr;
        plc_fn_ctrl_s ctrl;
    } plc_state_s;

endpackage

// >>> design/plc_regs.sv
// Purpose: power-down, parallel mode and lock configuration registers
// Assumes: apb slave on clk_sys, zero wait states, all inputs synchronous
// Notes:   rst_n is the power-up / hard reset and the only way to unlock
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"

module plc_regs
    import plc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire logic [1:0]   ext_setup,
    input  wire plc_base_t    fn_base,
    output plc_fn_ctrl_s      fn_ctrl
);

    plc_state_s st_r;
    plc_state_s st_nxt;
    logic       setup;
    logic       wr_acc;
    logic       unlocked;
    logic [2:0] hit;
    logic [3:0] dec_nxt;

    // no wait states: every access phase completes at once
    assign pready  = 1'b1;
    assign prdata  = st_r.prdata;
    assign pslverr = st_r.pslverr;
    assign fn_ctrl = st_r.ctrl;

    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite && pstrb[0];
    assign unlocked = st_r.ppl[`PLC_BIT_LOCK];

    // a register is open only in config state, with its index loaded and
    // the lock still set; the address alone never opens it
    always_comb begin
        hit[0] = (paddr == `PLC_ADDR_FPV) && st_r.cfg_mode && unlocked
                 && (st_r.cfg_index == `PLC_IDX_FPV);
        hit[1] = (paddr == `PLC_ADDR_PPL) && st_r.cfg_mode && unlocked
                 && (st_r.cfg_index == `PLC_IDX_PPL);
        hit[2] = (paddr == `PLC_ADDR_SPW) && st_r.cfg_mode && unlocked
                 && (st_r.cfg_index == `PLC_IDX_SPW);
    end

    // decoding follows the base address only, never the power bit
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dec
            assign dec_nxt[g] = (fn_base[g] >= `PLC_DECODE_MIN);
        end
    endgenerate

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;

        // read data and error are captured in the setup phase so that
        // they come from flip-flops during the access phase
        if (setup) begin
            st_nxt.prdata  = 32'h0;
            st_nxt.pslverr = 1'b0;
            if (paddr == `PLC_ADDR_FPV && hit[0]) begin
                st_nxt.prdata = {24'h0, st_r.fpv};
            end else if (paddr == `PLC_ADDR_PPL && hit[1]) begin
                st_nxt.prdata = {24'h0, st_r.ppl};
            end else if (paddr == `PLC_ADDR_SPW && hit[2]) begin
                st_nxt.prdata = {24'h0, st_r.spw};
            end else if (paddr == `PLC_ADDR_CFGMODE) begin
                st_nxt.prdata = {31'h0, st_r.cfg_mode};
            end else if (paddr == `PLC_ADDR_CFGINDEX) begin
                st_nxt.prdata = {26'h0, st_r.cfg_index};
            end else begin
                // blocked or unmapped: zero data, error flagged
                st_nxt.pslverr = 1'b1;
            end
        end

        // writes take effect at the access edge; fixed bits are forced
        if (wr_acc) begin
            if (paddr == `PLC_ADDR_FPV && hit[0]) begin
                st_nxt.fpv = (pwdata[7:0] & `PLC_WMASK_FPV)
                             | `PLC_ONES_FPV;
            end else if (paddr == `PLC_ADDR_PPL && hit[1]) begin
                st_nxt.ppl = (pwdata[7:0] & `PLC_WMASK_PPL)
                             | `PLC_ONES_PPL;
                // the lock can only be cleared by software
                st_nxt.ppl[`PLC_BIT_LOCK] = unlocked
                    && pwdata[`PLC_BIT_LOCK];
            end else if (paddr == `PLC_ADDR_SPW && hit[2]) begin
                st_nxt.spw = (pwdata[7:0] & `PLC_WMASK_SPW)
                             | `PLC_ONES_SPW;
            end else if (paddr == `PLC_ADDR_CFGMODE) begin
                st_nxt.cfg_mode = pwdata[`PLC_BIT_CFGMODE];
            end else if (paddr == `PLC_ADDR_CFGINDEX) begin
                st_nxt.cfg_index = pwdata[5:0];
            end
        end

        // power controls straight from the stored bits
        st_nxt.ctrl.pwr_on[`PLC_FN_FLOP] =
            st_nxt.fpv[`PLC_BIT_FLOP_PWR];
        st_nxt.ctrl.pwr_on[`PLC_FN_PP]  =
            st_nxt.ppl[`PLC_BIT_PP_PWR];
        st_nxt.ctrl.pwr_on[`PLC_FN_SP1] =
            st_nxt.spw[`PLC_BIT_SP1_PWR];
        st_nxt.ctrl.pwr_on[`PLC_FN_SP2] =
            st_nxt.spw[`PLC_BIT_SP2_PWR];
        // the infrared block shares the secondary port's power bit
        st_nxt.ctrl.fir_pwr_on = st_nxt.spw[`PLC_BIT_SP2_PWR];
        // range checking uses the same enable, ignoring power state
        st_nxt.ctrl.decode_en = dec_nxt;

        // parallel mode: printer unless extended modes are enabled
        if (st_nxt.ppl[`PLC_BIT_PP_MODE]) begin
            st_nxt.ctrl.pp_mode = PLC_PP_PRINTER;
        end else begin
            case (ext_setup)
                `PLC_EXT_STD:     st_nxt.ctrl.pp_mode = PLC_PP_STD;
                `PLC_EXT_EPP:     st_nxt.ctrl.pp_mode = PLC_PP_EPP_STD;
                `PLC_EXT_ECP:     st_nxt.ctrl.pp_mode = PLC_PP_ECP;
                default:          st_nxt.ctrl.pp_mode = PLC_PP_ECP_EPP;
            endcase
        end
    end

    // single state register; reset is power-up and hard reset alike
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r.fpv               <= `PLC_RST_FPV;
            st_r.ppl               <= `PLC_RST_PPL;
            st_r.spw               <= `PLC_RST_SPW;
            st_r.cfg_mode          <= 1'b0;
            st_r.cfg_index         <= 6'h00;
            st_r.prdata            <= 32'h0;
            st_r.pslverr           <= 1'b0;
            st_r.ctrl.pwr_on       <= 4'hf;
            st_r.ctrl.decode_en    <= 4'h0;
            st_r.ctrl.fir_pwr_on   <= 1'b1;
            st_r.ctrl.pp_mode      <= PLC_PP_PRINTER;
        end else begin
            st_r <= st_nxt;
        end
    end

    // helper: set once any configuration register write has landed
    logic touched_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            touched_r <= 1'b0;
        end else if (wr_acc && (hit[0] || hit[1] || hit[2])) begin
            touched_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // a write with the wrong index must leave the serial register alone
    property p_gate;
        wr_acc && paddr == `PLC_ADDR_SPW
            && st_r.cfg_index != `PLC_IDX_SPW
        |=> $stable(st_r.spw);
    endproperty
    a_gate: assert property (p_gate)
        else $error("serial register written with wrong index");

    // until software writes, every register shows its power-up value
    property p_rst00;
        !touched_r |-> st_r.fpv == `PLC_RST_FPV;
    endproperty
    a_rst00: assert property (p_rst00)
        else $error("floppy register not at power-up value");

    property p_rst01;
        !touched_r |-> st_r.ppl == `PLC_RST_PPL;
    endproperty
    a_rst01: assert property (p_rst01)
        else $error("parallel register not at power-up value");

    property p_rst02;
        !touched_r |-> st_r.spw == `PLC_RST_SPW;
    endproperty
    a_rst02: assert property (p_rst02)
        else $error("serial register not at power-up value");

    // fixed bits hold their value whatever was written
    property p_fix00;
        (st_r.fpv & ~`PLC_WMASK_FPV) == `PLC_ONES_FPV;
    endproperty
    a_fix00: assert property (p_fix00)
        else $error("floppy register fixed bits wrong");

    // the power output follows the write at the same edge
    property p_flop_pwr;
        wr_acc && hit[0] && !pwdata[`PLC_BIT_FLOP_PWR]
        |=> !fn_ctrl.pwr_on[`PLC_FN_FLOP];
    endproperty
    a_flop_pwr: assert property (p_flop_pwr)
        else $error("floppy controller not powered down");

    property p_pp_pwr;
        wr_acc && hit[1]
        |=> fn_ctrl.pwr_on[`PLC_FN_PP] == $past(pwdata[`PLC_BIT_PP_PWR]);
    endproperty
    a_pp_pwr: assert property (p_pp_pwr)
        else $error("parallel port power not as written");

    property p_sp1_pwr;
        wr_acc && hit[2]
        |=> fn_ctrl.pwr_on[`PLC_FN_SP1] == $past(pwdata[`PLC_BIT_SP1_PWR]);
    endproperty
    a_sp1_pwr: assert property (p_sp1_pwr)
        else $error("primary serial power not as written");

    // secondary port and infrared block always switch together
    property p_sp2_pwr;
        fn_ctrl.fir_pwr_on == fn_ctrl.pwr_on[`PLC_FN_SP2]
            && fn_ctrl.fir_pwr_on == st_r.spw[`PLC_BIT_SP2_PWR];
    endproperty
    a_sp2_pwr: assert property (p_sp2_pwr)
        else $error("secondary serial and infrared power differ");

    property p_valid;
        wr_acc && hit[0]
        |=> st_r.fpv[`PLC_BIT_VALID] == $past(pwdata[`PLC_BIT_VALID])
            && $stable(fn_ctrl.pp_mode);
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid flag not stored or had side effect");

    property p_decode;
        fn_base[`PLC_FN_SP1] < `PLC_DECODE_MIN
        |=> !fn_ctrl.decode_en[`PLC_FN_SP1];
    endproperty
    a_decode: assert property (p_decode)
        else $error("decoding left on below minimum base");

    // a powered-down function at a valid base keeps decoding
    property p_range;
        !fn_ctrl.pwr_on[`PLC_FN_FLOP]
            && fn_base[`PLC_FN_FLOP] >= `PLC_DECODE_MIN
        |=> fn_ctrl.decode_en[`PLC_FN_FLOP];
    endproperty
    a_range: assert property (p_range)
        else $error("powered-down function dropped out of decoding");

    // a write to the mode bit in the same cycle may change the mode
    property p_mode;
        !st_r.ppl[`PLC_BIT_PP_MODE] && ext_setup == `PLC_EXT_ECP
            && !(wr_acc && hit[1])
        |=> fn_ctrl.pp_mode == PLC_PP_ECP;
    endproperty
    a_mode: assert property (p_mode)
        else $error("extended parallel mode wrong");

    property p_printer;
        st_r.ppl[`PLC_BIT_PP_MODE] && !(wr_acc && hit[1])
        |=> fn_ctrl.pp_mode == PLC_PP_PRINTER;
    endproperty
    a_printer: assert property (p_printer)
        else $error("printer mode not selected");

    property p_fix01;
        (st_r.ppl & `PLC_FIXED_PPL) == `PLC_ONES_PPL;
    endproperty
    a_fix01: assert property (p_fix01)
        else $error("parallel register fixed bits wrong");

    property p_locked;
        setup && !unlocked && paddr == `PLC_ADDR_FPV
        |=> pslverr && prdata == 32'h0;
    endproperty
    a_locked: assert property (p_locked)
        else $error("access allowed while locked");

    // writes are refused while locked, not only reads
    property p_locked_wr;
        wr_acc && !unlocked
        |=> $stable(st_r.fpv) && $stable(st_r.spw) && $stable(st_r.ppl);
    endproperty
    a_locked_wr: assert property (p_locked_wr)
        else $error("register written while locked");

    property p_lock_sticky;
        !unlocked |=> !unlocked [*3];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock reopened without reset");

    property p_fix02;
        (st_r.spw & ~`PLC_WMASK_SPW) == `PLC_ONES_SPW;
    endproperty
    a_fix02: assert property (p_fix02)
        else $error("serial register fixed bits wrong");

endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the power and lock config registers
// Assumes: zero-wait apb slave, register model kept in the bench
// Notes:   random traffic from a fixed seed, lock tested last
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import plc_pkg::*;

    logic         clk_sys, rst_n, psel, penable, pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic [3:0]   pstrb;
    logic         pready;
    logic         pslverr;
    logic [1:0]   ext_setup;
    plc_base_t    fn_base;
    plc_fn_ctrl_s fn_ctrl;
    logic [7:0]   m_r [3];
    logic         m_mode;
    logic [5:0]   m_idx;
    logic [11:0]  r_addr;
    logic [31:0]  r_data;
    logic [11:0]  addrs [8] = '{12'h000, 12'h004, 12'h008, 12'h00c,
                                12'h100, 12'h104, 12'h108, 12'h200};
    int           n_mismatch, n_tests, cyc;

    plc_regs u_plc_regs (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_setup(ext_setup), .fn_base(fn_base), .fn_ctrl(fn_ctrl));

    // 20 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard, the run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // reset also restores the model, so a mid-run reset is legal
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (9) @(posedge clk_sys);
        @(negedge clk_sys);
        check(fn_ctrl.pwr_on, 4'hf, "reset power");
        check(fn_ctrl.pp_mode, 3'h0, "reset mode");
        @(posedge clk_sys);
        rst_n <= 1'b1;
        m_r[0] = 8'h28;
        m_r[1] = 8'h9c;
        m_r[2] = 8'h88;
        m_mode = 1'b0;
        m_idx  = 6'h00;
    endtask

    // one apb transfer, compared with the model, then the controls
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd, erd;
        logic        er, eer;
        int          n, i;
        i   = int'(a[3:2]);
        eer = 1'b0;
        erd = 32'h0;
        if (a == 12'h100)
            erd = {31'h0, m_mode};
        else if (a == 12'h104)
            erd = {26'h0, m_idx};
        else if (a < 12'h00c && m_mode && m_idx == i && m_r[1][7])
            erd = {24'h0, m_r[i]};
        else
            eer = 1'b1;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check(rd, erd, "read data");
        check(er, eer, "error");
        if (w && s[0] && !eer) begin
            case (a)
                12'h100: m_mode = d[0];
                12'h104: m_idx = d[5:0];
                12'h000: m_r[0] = {d[7], 3'h2, d[3], 3'h0};
                12'h004: m_r[1] = {m_r[1][7] & d[7], 3'h1, d[3:2], 2'h0};
                12'h008: m_r[2] = {d[7], 3'h0, d[3], 3'h0};
                default: ;
            endcase
        end
        @(negedge clk_sys);
        check(fn_ctrl.pwr_on, {m_r[2][7], m_r[2][3], m_r[1][2], m_r[0][3]},
              "power");
        check(fn_ctrl.fir_pwr_on, m_r[2][7], "infrared");
        for (n = 0; n < 4; n++)
            check(fn_ctrl.decode_en[n], fn_base[n] >= 11'h100, "decode");
        check(fn_ctrl.pp_mode, m_r[1][3] ? 3'h0 : {1'b0, ext_setup} + 3'h1,
              "mode");
    endtask

    initial begin
        rst_n     = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        pstrb     = 4'h0;
        ext_setup = 2'h0;
        fn_base   = '0;
        void'($urandom(32'h48e0f759));
        do_reset();
        // outside configuration state the floppy register is refused
        acc(1'b0, 12'h000, 32'h0, 4'hf);
        acc(1'b1, 12'h100, 32'h1, 4'hf);
        // wrong index refuses, right index gives defaults, then patterns
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 12'h104, (i + 1) % 3, 4'hf);
            acc(1'b0, 12'(4 * i), 32'h0, 4'hf);
            acc(1'b1, 12'h104, i, 4'hf);
            acc(1'b0, 12'(4 * i), 32'h0, 4'hf);
            for (int j = 0; j < 2; j++) begin
                acc(1'b1, 12'(4 * i), j ? 32'hffffffff : 32'h80, 4'hf);
                acc(1'b0, 12'(4 * i), 32'h0, 4'hf);
            end
        end
        // every extended parallel setup code
        acc(1'b1, 12'h104, 32'h1, 4'hf);
        acc(1'b1, 12'h004, 32'h84, 4'hf);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            ext_setup <= 2'(k);
            acc(1'b0, 12'h004, 32'h0, 4'hf);
        end
        // random traffic, base addresses straddle the decode limit
        for (int k = 0; k < 120; k++) begin
            @(posedge clk_sys);
            ext_setup <= 2'($urandom);
            for (int s = 0; s < 4; s++)
                fn_base[s] <= 11'($urandom_range(32'h110, 32'h0f0));
            r_addr = addrs[$urandom_range(7, 0)];
            r_data = $urandom;
            if (r_addr == 12'h104)
                r_data = $urandom_range(2, 0);
            if (r_addr == 12'h004)
                r_data[7] = 1'b1;
            acc(1'($urandom), r_addr, r_data, 4'($urandom));
        end
        // clearing the lock shuts the range until a hard reset
        acc(1'b1, 12'h100, 32'h1, 4'hf);
        acc(1'b1, 12'h104, 32'h1, 4'hf);
        acc(1'b1, 12'h004, 32'h0c, 4'hf);
        acc(1'b1, 12'h004, 32'h9c, 4'hf);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 12'h104, i, 4'hf);
            acc(1'b1, 12'(4 * i), 32'hff, 4'hf);
            acc(1'b0, 12'(4 * i), 32'h0, 4'hf);
        end
        do_reset();
        acc(1'b1, 12'h100, 32'h1, 4'hf);
        acc(1'b1, 12'h104, 32'h1, 4'hf);
        acc(1'b0, 12'h004, 32'h0, 4'hf);
        summarize();
    end
endmodule
`default_nettype wire
